// file: hw/dual_timer.sv
/*
 Dual 16-bit timer/counter with four modes, reached over Avalon-MM with waitrequest.
 Assumes count and gate pins are asynchronous; acknowledge inputs are on sys_clk.
*/
// Implementation choices: register access over Avalon-MM and the address map.
// Contract
// - timer function counts every machine cycle
// - count pin sampled once at S5P2
// - falling sample pair increments at next S3P1
// - per-timer source select and mode field
// - mode 0 is 13-bit counter
// - rollover sets overflow flag
// - count only when run and gate allow
// - run bit leaves counts untouched
// - gate bits at mode bits 7, 3
// - mode 1 uses full sixteen bits
// - mode 2 reloads low from high
// - timer 1 mode 3 freezes count
// - timer 0 split into two bytes
// - timer 1 overflows without flag in split
`timescale 1ns/10ps
`include "timer_regs.svh"

module dual_timer (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [`ADDR_WIDTH-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic count_input_zero,
   input wire logic count_input_one,
   input wire logic gate_pin_zero,
   input wire logic gate_pin_one,
   input wire logic flag0_ack,
   input wire logic flag1_ack,
   output logic timer0_overflow_flag,
   output logic timer1_overflow_flag,
   output logic baud_overflow
);
   import timer_pkg::*;

   // ==========================================================================
   // declarations
   logic [7:0] timer_mode_register;
   logic timer0_run_bit;
   logic timer1_run_bit;
   timer_pkg::count_byte_type low [2];
   timer_pkg::count_byte_type high [2];
   timer_pkg::count_byte_type next_low [2];
   timer_pkg::count_byte_type next_high [2];
   logic [1:0] low_ovf;
   logic [1:0] high_ovf;
   logic [1:0] low_en;
   logic [1:0] wr_low;
   logic [1:0] wr_high;
   logic [1:0] gate_meta;
   logic [1:0] gate_sync;
   logic [1:0] fall_pending;
   logic [3:0] phase;
   logic count_tick;
   logic sample_tick;
   logic ack;
   logic wr_hit;
   logic wr_mode;
   logic wr_ctl;
   logic set_flag0;
   logic set_flag1;
   timer_mode_type mode0;
   timer_mode_type mode1;

   // ==========================================================================
   // machine cycle timing and count pins
   machine_phase #(
      .CYCLE_LEN(`OSC_PER_MACHINE_CYCLE)
   ) phase_gen (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .phase(phase),
      .count_tick(count_tick),
      .sample_tick(sample_tick)
   );

   pin_sampler #(
      .WIDTH(2)
   ) count_pins (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .pins({count_input_one, count_input_zero}),
      .sample_tick(sample_tick),
      .consume_tick(count_tick),
      .fall_pending(fall_pending)
   );

   // gate pins pass two flip-flops
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gate_meta <= 2'h0;
         gate_sync <= 2'h0;
      end else if (clk_en) begin
         gate_meta <= {gate_pin_one, gate_pin_zero};
         gate_sync <= gate_meta;
      end
   end

   // ==========================================================================
   // bus slave, one wait state per access
   assign waitrequest = (read || write) && !ack;
   assign wr_hit = write && ack && clk_en && byteenable[0];
   assign wr_mode = wr_hit && (address == `OFF_MODE);
   assign wr_ctl = wr_hit && (address == `OFF_CONTROL);
   assign wr_low[0] = wr_hit && (address == `OFF_T0_LOW);
   assign wr_high[0] = wr_hit && (address == `OFF_T0_HIGH);
   assign wr_low[1] = wr_hit && (address == `OFF_T1_LOW);
   assign wr_high[1] = wr_hit && (address == `OFF_T1_HIGH);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ack <= 1'b0;
      end else if (clk_en) begin
         ack <= (read || write) && !ack;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         readdata <= `RST_WORD;
      end else if (clk_en && read && !ack) begin
         readdata <= 32'h0000_0000;
         case (address)
            `OFF_MODE: readdata[7:0] <= timer_mode_register;
            `OFF_CONTROL: readdata[7:0] <= {timer1_overflow_flag, timer1_run_bit,
               timer0_overflow_flag, timer0_run_bit, 4'h0};
            `OFF_T0_LOW: readdata[7:0] <= low[0];
            `OFF_T0_HIGH: readdata[7:0] <= high[0];
            `OFF_T1_LOW: readdata[7:0] <= low[1];
            `OFF_T1_HIGH: readdata[7:0] <= high[1];
            default: readdata[7:0] <= 8'h00;
         endcase
      end
   end

   // ==========================================================================
   // mode and run control
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_mode_register <= `RST_BYTE;
      end else if (wr_mode) begin
         timer_mode_register <= writedata[7:0];
      end
   end

   // run bits touch nothing but themselves
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer0_run_bit <= 1'b0;
         timer1_run_bit <= 1'b0;
      end else if (wr_ctl) begin
         timer0_run_bit <= writedata[`CTL_RUN0];
         timer1_run_bit <= writedata[`CTL_RUN1];
      end
   end

   assign mode0 = timer_mode_type'(timer_mode_register[`MODE_SEL0_HI:`MODE_SEL0_LO]);
   assign mode1 = timer_mode_type'(timer_mode_register[`MODE_SEL1_HI:`MODE_SEL1_LO]);

   // ==========================================================================
   // count enables, one per timer
   always_comb begin
      low_en[0] = count_tick && timer0_run_bit
         && (!timer_mode_register[`MODE_GATE0] || gate_sync[0])
         && (!timer_mode_register[`MODE_CT0] || fall_pending[0]);
      low_en[1] = count_tick && timer1_run_bit
         && (!timer_mode_register[`MODE_GATE1] || gate_sync[1])
         && (!timer_mode_register[`MODE_CT1] || fall_pending[1])
         && (mode1 != MODE_SPLIT);
   end

   // ==========================================================================
   // per-timer next count and rollover
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : timer_gen
         timer_mode_type mode;
         logic high_en;
         logic [12:0] c13;
         logic [15:0] c16;

         assign mode = (i == 0) ? mode0 : mode1;
         // split high byte: machine cycles, timer 1 run bit
         assign high_en = (i == 0) && count_tick && timer1_run_bit;

         always_comb begin
            next_low[i] = low[i];
            next_high[i] = high[i];
            low_ovf[i] = 1'b0;
            high_ovf[i] = 1'b0;
            c13 = {high[i], low[i][`LOW_13BIT_MSB:0]} + 13'h0001;
            c16 = {high[i], low[i]} + 16'h0001;
            case (mode)
               MODE_13BIT: begin
                  if (low_en[i]) begin
                     // upper low-byte bits left as they stand
                     next_low[i][`LOW_13BIT_MSB:0] = c13[`LOW_13BIT_MSB:0];
                     next_high[i] = c13[12:5];
                     low_ovf[i] = (c13 == 13'h0000);
                  end
               end
               MODE_16BIT: begin
                  if (low_en[i]) begin
                     next_low[i] = c16[7:0];
                     next_high[i] = c16[15:8];
                     low_ovf[i] = (c16 == 16'h0000);
                  end
               end
               MODE_RELOAD8: begin
                  if (low_en[i]) begin
                     if (low[i] == 8'hFF) begin
                        next_low[i] = high[i];
                        low_ovf[i] = 1'b1;
                     end else begin
                        next_low[i] = low[i] + 8'h01;
                     end
                  end
               end
               MODE_SPLIT: begin
                  if (low_en[i]) begin
                     next_low[i] = low[i] + 8'h01;
                     low_ovf[i] = (low[i] == 8'hFF);
                  end
                  if (high_en) begin
                     next_high[i] = high[i] + 8'h01;
                     high_ovf[i] = (high[i] == 8'hFF);
                  end
               end
               default: begin
                  next_low[i] = low[i];
               end
            endcase
         end

         // software write wins over a count in the same cycle
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               low[i] <= `RST_BYTE;
               high[i] <= `RST_BYTE;
            end else if (clk_en) begin
               low[i] <= wr_low[i] ? writedata[7:0] : next_low[i];
               high[i] <= wr_high[i] ? writedata[7:0] : next_high[i];
            end
         end
      end
   endgenerate

   // ==========================================================================
   // overflow flags and baud source
   assign set_flag0 = low_ovf[0];
   // split mode hands the timer 1 flag to the timer 0 high byte
   assign set_flag1 = (mode0 == MODE_SPLIT) ? high_ovf[0] : low_ovf[1];

   // set wins over any clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer0_overflow_flag <= 1'b0;
         timer1_overflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (set_flag0) begin
            timer0_overflow_flag <= 1'b1;
         end else if (flag0_ack || (wr_ctl && !writedata[`CTL_FLAG0])) begin
            timer0_overflow_flag <= 1'b0;
         end else if (wr_ctl) begin
            timer0_overflow_flag <= 1'b1;
         end
         if (set_flag1) begin
            timer1_overflow_flag <= 1'b1;
         end else if (flag1_ack || (wr_ctl && !writedata[`CTL_FLAG1])) begin
            timer1_overflow_flag <= 1'b0;
         end else if (wr_ctl) begin
            timer1_overflow_flag <= 1'b1;
         end
      end
   end

   // timer 1 rollover pulse, flag or not
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         baud_overflow <= 1'b0;
      end else if (clk_en) begin
         baud_overflow <= low_ovf[1];
      end
   end

   // ==========================================================================
   // checks
   count_phase_a: assert property (@(posedge sys_clk) disable iff (srst)
      (low[0] != $past(low[0])) && !$past(wr_low[0]) |-> $past(count_tick))
      else $error("timer 0 low byte changed outside S3P1");

   timer_rate_a: assert property (@(posedge sys_clk) disable iff (srst)
      count_tick && timer0_run_bit && !timer_mode_register[`MODE_GATE0]
      && !timer_mode_register[`MODE_CT0] && (mode0 == MODE_16BIT)
      && !wr_low[0] && !wr_high[0]
      |=> {high[0], low[0]} == $past({high[0], low[0]}) + 16'h0001)
      else $error("timer 0 missed a machine cycle count");

   edge_count_a: assert property (@(posedge sys_clk) disable iff (srst)
      count_tick && fall_pending[0] && timer0_run_bit && timer_mode_register[`MODE_CT0]
      && !timer_mode_register[`MODE_GATE0] && (mode0 == MODE_RELOAD8) && !wr_low[0]
      && (low[0] != 8'hFF)
      |=> low[0] == $past(low[0]) + 8'h01)
      else $error("captured edge not counted");

   run_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!timer0_run_bit || (timer_mode_register[`MODE_GATE0] && !gate_sync[0]))
      && (mode0 != MODE_SPLIT) && !wr_low[0] && !wr_high[0]
      |=> $stable(low[0]) && $stable(high[0]))
      else $error("timer 0 counted while stopped");

   reload_a: assert property (@(posedge sys_clk) disable iff (srst)
      (mode1 == MODE_RELOAD8) && (mode0 != MODE_SPLIT) && low_en[1] && (low[1] == 8'hFF)
      && !wr_low[1] && !wr_high[1]
      |=> (low[1] == $past(high[1])) && $stable(high[1]) && timer1_overflow_flag)
      else $error("mode 2 reload failed");

   freeze_a: assert property (@(posedge sys_clk) disable iff (srst)
      (mode1 == MODE_SPLIT) && !wr_low[1] && !wr_high[1]
      |=> $stable(low[1]) && $stable(high[1]))
      else $error("timer 1 moved in mode 3");

   flag_set_a: assert property (@(posedge sys_clk) disable iff (srst)
      clk_en && set_flag0 |=> timer0_overflow_flag [*1] ##0 baud_overflow == $past(low_ovf[1]))
      else $error("overflow did not raise the flag");

   flag_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      timer1_overflow_flag && !flag1_ack && !wr_ctl |=> timer1_overflow_flag)
      else $error("flag dropped without a clear");

   split_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
      (mode0 == MODE_SPLIT) && low_ovf[1] && !high_ovf[0] && !timer1_overflow_flag
      && !wr_ctl |=> !timer1_overflow_flag && baud_overflow)
      else $error("timer 1 raised a flag while timer 0 is split");

endmodule

// file: hw/timer_regs.svh
/*
 Register offsets, field positions, reset values and phase timing for the dual timer/counter.
 Assumes sys_clk is the oscillator, so one oscillator period equals one sys_clk cycle.
*/
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ==========================================================================
// register byte addresses
`define ADDR_WIDTH 5
`define OFF_MODE 5'h00
`define OFF_CONTROL 5'h04
`define OFF_T0_LOW 5'h08
`define OFF_T0_HIGH 5'h0C
`define OFF_T1_LOW 5'h10
`define OFF_T1_HIGH 5'h14

// ==========================================================================
// mode register fields
`define MODE_GATE1 7
`define MODE_CT1 6
`define MODE_SEL1_HI 5
`define MODE_SEL1_LO 4
`define MODE_GATE0 3
`define MODE_CT0 2
`define MODE_SEL0_HI 1
`define MODE_SEL0_LO 0

// ==========================================================================
// control register fields
`define CTL_FLAG1 7
`define CTL_RUN1 6
`define CTL_FLAG0 5
`define CTL_RUN0 4

// ==========================================================================
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

// ==========================================================================
// machine cycle timing, in oscillator periods
`define OSC_PER_MACHINE_CYCLE 12
`define PHASE_S3P1 4'h4
`define PHASE_S5P2 4'h9
`define LOW_13BIT_MSB 4

`endif

// file: hw/timer_pkg.sv
/*
 Types shared by the dual timer/counter design files.
 Assumes the register header supplies all numeric constants.
*/
package timer_pkg;

   // ==========================================================================
   // operating mode field encoding
   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD8 = 2'h2,
      MODE_SPLIT = 2'h3
   } timer_mode_type;

   typedef logic [7:0] count_byte_type;

endpackage

// file: hw/machine_phase.sv
/*
 Machine cycle phase generator: counts oscillator periods within a machine cycle.
 Assumes sys_clk is the oscillator and clk_en freezes the sequence.
*/
`timescale 1ns/10ps
`include "timer_regs.svh"

module machine_phase #(
   parameter int CYCLE_LEN = `OSC_PER_MACHINE_CYCLE
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   output logic [3:0] phase,
   output logic count_tick,
   output logic sample_tick
);
   import timer_pkg::*;

   // ==========================================================================
   // phase counter, S1P1 through S6P2
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase <= 4'h0;
      end else if (clk_en) begin
         if (phase == 4'(CYCLE_LEN - 1)) begin
            phase <= 4'h0;
         end else begin
            phase <= phase + 4'h1;
         end
      end
   end

   // ==========================================================================
   // phase strobes
   assign count_tick = clk_en && (phase == `PHASE_S3P1);
   assign sample_tick = clk_en && (phase == `PHASE_S5P2);

endmodule

// file: hw/pin_sampler.sv
/*
 Count input sampler: two-stage synchroniser, one sample per machine cycle, falling edge capture.
 Assumes sample_tick and consume_tick come from the machine phase generator.
*/
`timescale 1ns/10ps

module pin_sampler #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] pins,
   input wire logic sample_tick,
   input wire logic consume_tick,
   output logic [WIDTH-1:0] fall_pending
);
   import timer_pkg::*;

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] synced;
   logic [WIDTH-1:0] sampled;

   // ==========================================================================
   // synchroniser and per-bit edge capture
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta <= '0;
         synced <= '0;
      end else if (clk_en) begin
         meta <= pins;
         synced <= meta;
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : bit_gen
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               sampled[i] <= 1'b0;
               fall_pending[i] <= 1'b0;
            end else if (sample_tick) begin
               sampled[i] <= synced[i];
               fall_pending[i] <= sampled[i] && !synced[i];
            end else if (consume_tick) begin
               fall_pending[i] <= 1'b0;
            end
         end

         fall_phase_a: assert property (@(posedge sys_clk) disable iff (srst)
            $rose(fall_pending[i]) |-> $past(sample_tick))
            else $error("edge captured outside the sample phase");
      end
   endgenerate

endmodule

// file: verification/pin_source.sv
/*
 Far-side model of the count and gate pins of the dual timer/counter.
 Assumes the bench calls its tasks and that sys_clk is the oscillator.
*/
`timescale 1ns/10ps

module pin_source (
   input wire logic sys_clk,
   output logic count_input_zero,
   output logic count_input_one,
   output logic gate_pin_zero,
   output logic gate_pin_one
);
   // ==========================================================================
   // idle levels: count pins pulled high, gates closed
   initial begin
      count_input_zero = 1'b1;
      count_input_one = 1'b1;
      gate_pin_zero = 1'b0;
      gate_pin_one = 1'b0;
   end

   // ==========================================================================
   // falling-edge events, each level held longer than a machine cycle
   task automatic pulse(input int which, input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         count_input_zero <= (which == 0) ? 1'b0 : count_input_zero;
         count_input_one <= (which == 1) ? 1'b0 : count_input_one;
         repeat (16) @(posedge sys_clk);
         count_input_zero <= 1'b1;
         count_input_one <= 1'b1;
         repeat (16) @(posedge sys_clk);
      end
   endtask

   task automatic set_gates(input logic g0, input logic g1);
      @(posedge sys_clk);
      gate_pin_zero <= g0;
      gate_pin_one <= g1;
   endtask
endmodule

// file: verification/dual_timer_counter_modes_bench.sv
/*
 Self-checking bench for the dual timer/counter: mode table, events, split mode, flags, reset.
 Assumes one wait state per bus access and twelve sys_clk cycles per machine cycle.
*/
`timescale 1ns/10ps
`include "timer_regs.svh"

module dual_timer_counter_modes_bench;
   typedef struct {
      logic t;
      logic g;
      logic [7:0] mode;
      logic [7:0] lo;
      logic [7:0] hi;
      int n;
      logic [7:0] elo;
      logic [7:0] ehi;
      logic ef;
   } row_type;

   logic sys_clk;
   logic srst = 1'b1;
   logic [`ADDR_WIDTH-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic clk_en = 1'b1;
   logic [31:0] readdata;
   logic waitrequest;
   logic count_input_zero, count_input_one, gate_pin_zero, gate_pin_one;
   logic flag0_ack = 1'b0;
   logic flag1_ack = 1'b0;
   logic timer0_overflow_flag, timer1_overflow_flag, baud_overflow;
   int bad_count = 0;
   int tests_run = 0;
   int baud_seen = 0;
   row_type r;
   logic [`ADDR_WIDTH-1:0] lo_a, hi_a;
   logic [7:0] junk;

   // ==========================================================================
   // timer rows: unit, gate level, mode, preload, machine cycles, expected
   row_type rows [10] = '{
      '{1'b0, 1'b0, 8'h00, 8'h1F, 8'hFF, 3, 8'h02, 8'h00, 1'b1},
      '{1'b0, 1'b0, 8'h01, 8'hFE, 8'hFF, 4, 8'h02, 8'h00, 1'b1},
      '{1'b0, 1'b0, 8'h02, 8'hFE, 8'h80, 4, 8'h82, 8'h80, 1'b1},
      '{1'b0, 1'b0, 8'h09, 8'h40, 8'h00, 5, 8'h40, 8'h00, 1'b0},
      '{1'b0, 1'b1, 8'h09, 8'h10, 8'h00, 5, 8'h15, 8'h00, 1'b0},
      '{1'b1, 1'b0, 8'h10, 8'hFE, 8'hFF, 4, 8'h02, 8'h00, 1'b1},
      '{1'b1, 1'b0, 8'h90, 8'h40, 8'h00, 5, 8'h40, 8'h00, 1'b0},
      '{1'b1, 1'b1, 8'h90, 8'h10, 8'h00, 5, 8'h15, 8'h00, 1'b0},
      '{1'b1, 1'b0, 8'h20, 8'hFE, 8'h80, 4, 8'h82, 8'h80, 1'b1},
      '{1'b1, 1'b0, 8'h00, 8'h1F, 8'hFF, 3, 8'h02, 8'h00, 1'b1}
   };

   dual_timer i_dual_timer (
      .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .count_input_zero(count_input_zero),
      .count_input_one(count_input_one), .gate_pin_zero(gate_pin_zero),
      .gate_pin_one(gate_pin_one), .flag0_ack(flag0_ack), .flag1_ack(flag1_ack),
      .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
      .baud_overflow(baud_overflow)
   );

   pin_source i_pin_source (
      .sys_clk(sys_clk), .count_input_zero(count_input_zero),
      .count_input_one(count_input_one), .gate_pin_zero(gate_pin_zero),
      .gate_pin_one(gate_pin_one)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (baud_overflow === 1'b1) baud_seen++;
   end

   // ==========================================================================
   // bus access, compares, verdict
   task automatic bus(input logic wr_n, input logic [`ADDR_WIDTH-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      address <= a;
      read <= !wr_n;
      write <= wr_n;
      writedata <= {24'h00_0000, d};
      @(posedge sys_clk);
      while (waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge sys_clk);
      end
      if (n == 20) bad_count++;
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [`ADDR_WIDTH-1:0] a, input logic [7:0] d);
      bus(1'b1, a, d, junk);
   endtask

   task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", name, e, s);
      end
   endtask

   task automatic check_bit(input string name, input logic e, input logic s);
      check_byte(name, {7'h00, e}, {7'h00, s});
   endtask

   task automatic rd_chk(input logic [`ADDR_WIDTH-1:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check_byte(nm, e, q);
   endtask

   // run for exactly n machine cycles between the two control writes
   task automatic run_for(input logic [7:0] ctl, input int n);
      wr(`OFF_CONTROL, ctl);
      repeat (12 * n - 3) @(posedge sys_clk);
   endtask

   task automatic pulse_ack(input logic which);
      @(posedge sys_clk);
      flag0_ack <= !which;
      flag1_ack <= which;
      @(posedge sys_clk);
      flag0_ack <= 1'b0;
      flag1_ack <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      bad_count++;
      final_report();
   end

   // ==========================================================================
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      for (int a = 0; a < 6; a++) rd_chk(5'(4 * a), 8'h00, "reset value");
      check_bit("reset flag0", 1'b0, timer0_overflow_flag);
      wr(5'h18, 8'hAA);
      rd_chk(5'h18, 8'h00, "unmapped");
      @(posedge sys_clk) byteenable <= 4'h0;
      wr(`OFF_T0_LOW, 8'h77);
      @(posedge sys_clk) byteenable <= 4'hF;
      rd_chk(`OFF_T0_LOW, 8'h00, "lane off");
      for (int i = 0; i < 10; i++) begin
         r = rows[i];
         lo_a = r.t ? `OFF_T1_LOW : `OFF_T0_LOW;
         hi_a = r.t ? `OFF_T1_HIGH : `OFF_T0_HIGH;
         i_pin_source.set_gates(r.g, r.g);
         wr(`OFF_CONTROL, 8'h00);
         wr(`OFF_MODE, r.mode);
         wr(lo_a, r.lo);
         wr(hi_a, r.hi);
         repeat (4) @(posedge sys_clk);
         run_for(r.t ? 8'h40 : 8'h10, r.n);
         check_bit("flag", r.ef, r.t ? timer1_overflow_flag : timer0_overflow_flag);
         wr(`OFF_CONTROL, 8'h00);
         rd_chk(lo_a, r.elo, "low");
         rd_chk(hi_a, r.ehi, "high");
      end
      // events on both count pins
      wr(`OFF_MODE, 8'h56);
      wr(`OFF_T0_LOW, 8'h00);
      wr(`OFF_T1_LOW, 8'h00);
      wr(`OFF_CONTROL, 8'h50);
      i_pin_source.pulse(0, 3);
      i_pin_source.pulse(1, 2);
      repeat (40) @(posedge sys_clk);
      wr(`OFF_CONTROL, 8'h00);
      rd_chk(`OFF_T0_LOW, 8'h03, "t0 events");
      rd_chk(`OFF_T1_LOW, 8'h02, "t1 events");
      // split timer 0, timer 1 as overflow source
      wr(`OFF_MODE, 8'h23);
      wr(`OFF_T0_LOW, 8'h30);
      wr(`OFF_T0_HIGH, 8'h00);
      wr(`OFF_T1_LOW, 8'hFF);
      wr(`OFF_T1_HIGH, 8'hFF);
      baud_seen = 0;
      run_for(8'h40, 5);
      check_bit("split flag1", 1'b0, timer1_overflow_flag);
      wr(`OFF_CONTROL, 8'h00);
      repeat (3) @(posedge sys_clk);
      check_byte("baud pulses", 8'h05, 8'(baud_seen));
      rd_chk(`OFF_T0_HIGH, 8'h05, "split high");
      rd_chk(`OFF_T0_LOW, 8'h30, "split low idle");
      wr(`OFF_T0_HIGH, 8'hFE);
      run_for(8'h40, 4);
      check_bit("split high flag1", 1'b1, timer1_overflow_flag);
      wr(`OFF_CONTROL, 8'h00);
      run_for(8'h10, 3);
      check_bit("split low flag0", 1'b0, timer0_overflow_flag);
      wr(`OFF_CONTROL, 8'h00);
      rd_chk(`OFF_T0_LOW, 8'h33, "split low");
      rd_chk(`OFF_T0_HIGH, 8'h02, "split high kept");
      wr(`OFF_MODE, 8'h33);
      wr(`OFF_T1_LOW, 8'h20);
      baud_seen = 0;
      run_for(8'h40, 5);
      wr(`OFF_CONTROL, 8'h00);
      rd_chk(`OFF_T1_LOW, 8'h20, "t1 frozen");
      check_byte("frozen baud", 8'h00, 8'(baud_seen));
      wr(`OFF_MODE, 8'h13);
      run_for(8'h40, 5);
      wr(`OFF_CONTROL, 8'h00);
      rd_chk(`OFF_T1_LOW, 8'h25, "t1 resumed");
      // sticky flags and acknowledge
      wr(`OFF_MODE, 8'h00);
      wr(`OFF_CONTROL, 8'hA0);
      repeat (30) @(posedge sys_clk);
      check_bit("flag0 held", 1'b1, timer0_overflow_flag);
      check_bit("flag1 held", 1'b1, timer1_overflow_flag);
      clk_en <= 1'b0;
      pulse_ack(1'b1);
      clk_en <= 1'b1;
      check_bit("flag1 frozen", 1'b1, timer1_overflow_flag);
      pulse_ack(1'b1);
      check_bit("flag1 acked", 1'b0, timer1_overflow_flag);
      rd_chk(`OFF_CONTROL, 8'h20, "control");
      pulse_ack(1'b0);
      check_bit("flag0 acked", 1'b0, timer0_overflow_flag);
      // reset in mid-run
      wr(`OFF_T0_LOW, 8'h55);
      wr(`OFF_CONTROL, 8'h10);
      @(posedge sys_clk) srst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      rd_chk(`OFF_T0_LOW, 8'h00, "low after reset");
      rd_chk(`OFF_CONTROL, 8'h00, "control after reset");
      final_report();
   end
endmodule
